/* File: design/refcond_consts.svh */
// Register indices, fields, reset values and timing for refcond.
// Assumes byte address = 4 * index on a 32-bit AXI4-Lite bus.
`ifndef REFCOND_CONSTS_SVH
`define REFCOND_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define REG_TEST_CONTROL 8'h03
`define REG_REF_FREQ_CFG_0 8'h20
`define REG_REF_FREQ_CFG_13 8'h2D
`define REG_INPUT_NETWORK_CONFIG 8'h34
`define REG_DIFF_RX_SELECT 8'h36
`define REG_DIVIDER_VALUE_A 8'h46
`define REG_DIVIDER_VALUE_B 8'h47
`define REG_AVAILABLE_LO 8'h50
`define REG_AVAILABLE_HI 8'h51
`define REG_COMPOSITE_STATUS 8'h52
`define REG_CFG_ERROR_LO 8'h53
`define REG_CFG_ERROR_HI 8'h54
`define REG_PRIORITY_0 8'h58
`define REG_PRIORITY_6 8'h5E

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_NETWORK_TYPE 2
`define BIT_REFERENCE_EDGE 2
`define SYNC_RATE_LSB 0
`define SYNC_RATE_MSB 1
`define DIVIDER_VALUE_A_HI_MSB 5

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define RST_TEST_CONTROL 8'h00
`define RST_INPUT_NETWORK_CONFIG 8'h00
`define RST_DIFF_RX_SELECT 8'h02
`define RST_DIVIDER_VALUE 8'h00
`define DIVIDER_VALUE_A_MIN 14'h0001
`define DIVIDER_VALUE_A_MAX 14'h30D3
`define PRIO_PORT_ELEVEN_MASTER 4'hC
`define PRIO_PORT_ELEVEN_SLAVE 4'h1
`define AMI_MARKS_PER_FRAME 4'h8
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define CLK_MHZ 100
`define T_FRAME_8K_US 125
`define T_MFRAME_2K_US 500
`define T_LOSS_OF_ACTIVITY_US 1000

`endif

/* File: design/refcond_pkg.sv */
// Types for reference input conditioning.
// Assumes numbers come from refcond_consts.svh.
package refcond_pkg;

  // ----------------------------------------------------------------
  // Spot frequency codes (low nibble of a frequency register)
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FC_8K = 4'h0,
    FC_T1E1 = 4'h1,
    FC_6M48 = 4'h2,
    FC_19M44 = 4'h3,
    FC_25M92 = 4'h4,
    FC_38M88 = 4'h5,
    FC_51M84 = 4'h6,
    FC_77M76 = 4'h7,
    FC_155M52 = 4'h8,
    FC_2K = 4'h9,
    FC_4K = 4'hA,
    FC_COMPOSITE = 4'hB
  } freq_code_t;

  typedef struct packed {
    logic integer_divider_mode;
    logic auto_eight_khz_mode;
    logic [1:0] bucket_id;
    logic [3:0] freq_code;
  } ref_cfg_t;

  typedef enum logic [1:0] {
    SYNC_2K = 2'h0,
    SYNC_4K = 2'h1,
    SYNC_8K = 2'h2
  } sync_rate_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_STRAP = 3'b010,
    ST_RUN = 3'b100
  } boot_state_t;

  typedef struct packed {
    logic loss;
    logic cfg_error;
    logic available;
    logic freq_check_en;
  } ref_status_t;

  // Ratio to 8 kHz per spot code; 1 where none applies
  function automatic logic [14:0] auto_ratio(input logic [3:0] code, input logic sonet);
    logic [14:0] r;
    r = 15'h0001;
    case (code)
      FC_T1E1: r = sonet ? 15'h00C1 : 15'h0100;
      FC_6M48: r = 15'h032A;
      FC_19M44: r = 15'h097E;
      FC_25M92: r = 15'h0CA8;
      FC_38M88: r = 15'h12FC;
      FC_51M84: r = 15'h1950;
      FC_77M76: r = 15'h25F8;
      FC_155M52: r = 15'h4BF0;
      default: r = 15'h0001;
    endcase
    return r;
  endfunction : auto_ratio

  // Frequency register reset value per port index
  function automatic logic [7:0] default_cfg(input int idx);
    logic [7:0] v;
    if (idx < 2) begin
      v = {4'h0, FC_COMPOSITE};
    end else if (idx < 4) begin
      v = {4'h0, FC_8K};
    end else if (idx < 10) begin
      v = {4'h0, FC_19M44};
    end else begin
      v = {4'h0, FC_T1E1};
    end
    return v;
  endfunction : default_cfg

endpackage : refcond_pkg

/* File: design/reference_input_conditioning.sv */
// Reference input conditioning: dividers, monitors, straps, sync.
// Assumes inputs synchronous to CLK_IN,
// at most one reference level change
// per clock.
//
// What this block does
// - 2 kHz sync resets 2k/8k dividers
// - Accept 4k/8k sync, slower outputs unaligned
// - Mode register bit 2 picks SONET/SDH
// - Network type loaded from pin after reset
// - One frequency register per input
// - Direct lock compares at spot frequency
// - Bit 6 enables automatic divide to 8k
// - Test register bit 2 picks edge of divided pin inputs
// - Bit 7 selects manual divider, 8k result
// - Manual divide by N+1, N 1..12499
// - N held in two registers, binary value
// - Pattern 10XX0000: manual divide, XX bucket ID
// - 155 MHz direct lock halved automatically
// - PECL or LVDS chosen per differential input
// - Composite clock pattern deviations detected
// - Channel codes and reset priorities in order
// - Port eleven priority 12 master, 1 slave
// - Single-ended: listed spot frequencies only
// - Differential inputs add 155.52 MHz spot
// - Frequency check only without loss or irregularity
// - 1 ms inactivity loss; lost inputs unavailable
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "refcond_consts.svh"

module reference_input_conditioning
  import refcond_pkg::*;
#(
  parameter int NUM_REFS = 14,
  parameter int AXI_ADDR_W = 12,
  parameter int FRAME_8K_CYC = `T_FRAME_8K_US * `CLK_MHZ,
  parameter int MFRAME_2K_CYC = `T_MFRAME_2K_US * `CLK_MHZ,
  parameter int LOSS_CYC = `T_LOSS_OF_ACTIVITY_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // AXI4-Lite slave
  input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // Strap pins
  input wire logic NETWORK_TYPE_SELECT_IN,
  input wire logic MASTER_SLAVE_PIN_IN,
  // Reference inputs
  input wire logic [NUM_REFS-1:0] REF_IN,
  input wire logic [1:0] AMI_POS_MARK_IN,
  input wire logic [1:0] AMI_NEG_MARK_IN,
  input wire logic SYNC_IN,
  // Monitor side
  input wire logic [NUM_REFS-1:0] IRREGULAR_IN,
  input wire logic [NUM_REFS-1:0] OUT_OF_BAND_IN,
  output logic [NUM_REFS-1:0] PHASE_EVENT_OUT,
  output logic [NUM_REFS-1:0] FREQ_CHECK_EN_OUT,
  output logic [NUM_REFS-1:0] AVAILABLE_OUT,
  output logic [NUM_REFS*4-1:0] PRIORITY_OUT,
  output logic [1:0] DIFF_PECL_SEL_OUT,
  output logic NETWORK_SONET_OUT,
  // Frame sync outputs
  output logic FRAME_8K_OUT,
  output logic MFRAME_2K_OUT
);

  localparam int FW = $clog2(FRAME_8K_CYC + 1);
  localparam int MW = $clog2(MFRAME_2K_CYC + 1);
  localparam int LW = $clog2(LOSS_CYC + 1);
  localparam int DIFF_A = 4;
  localparam int DIFF_B = 5;
  localparam int PORT_ELEVEN = 10;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] test_control_r;
  logic [7:0] input_network_config_r;
  logic [7:0] differential_receiver_select_r;
  logic [7:0] divider_value_a_r;
  logic [7:0] divider_value_b_r;
  logic [7:0] ref_freq_cfg_r [NUM_REFS];
  logic [3:0] priority_r [NUM_REFS];
  logic [1:0] ami_dev_r;
  boot_state_t boot_r;

  ref_status_t status [NUM_REFS];
  logic [NUM_REFS-1:0] loss_v;
  logic [NUM_REFS-1:0] err_v;
  logic [1:0] ami_mark;
  logic [1:0] ami_dev_set;
  logic [13:0] divider_value_a_raw;
  logic [13:0] divider_value_a_eff;
  logic network_sonet;
  logic edge_falling;

  assign network_sonet = input_network_config_r[`BIT_NETWORK_TYPE];
  assign edge_falling = test_control_r[`BIT_REFERENCE_EDGE];
  assign NETWORK_SONET_OUT = network_sonet;
  assign DIFF_PECL_SEL_OUT = differential_receiver_select_r[1:0];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic wr_take;
  logic rd_take;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [1:0] wr_clr;

  // AW and W taken together; one write at a time
  assign S_AXI_AWREADY_OUT = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !S_AXI_BVALID_OUT;
  assign S_AXI_WREADY_OUT = S_AXI_AWREADY_OUT;
  assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
  assign wr_take = S_AXI_AWREADY_OUT;
  assign rd_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  assign wr_idx = S_AXI_AWADDR_IN[9:2];
  assign rd_idx = S_AXI_ARADDR_IN[9:2];

  function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    mapped = (a[AXI_ADDR_W-1:10] == '0) && (i == `REG_TEST_CONTROL
      || (i >= `REG_REF_FREQ_CFG_0 && i <= `REG_REF_FREQ_CFG_13)
      || i == `REG_INPUT_NETWORK_CONFIG || i == `REG_DIFF_RX_SELECT
      || i == `REG_DIVIDER_VALUE_A || i == `REG_DIVIDER_VALUE_B
      || (i >= `REG_AVAILABLE_LO && i <= `REG_CFG_ERROR_HI)
      || (i >= `REG_PRIORITY_0 && i <= `REG_PRIORITY_6));
  endfunction : mapped

  assign wr_hit = mapped(S_AXI_AWADDR_IN);
  assign rd_hit = mapped(S_AXI_ARADDR_IN);
  assign wr_clr = (wr_take && wr_hit && S_AXI_WSTRB_IN[0] && wr_idx == `REG_COMPOSITE_STATUS)
    ? S_AXI_WDATA_IN[3:2] : 2'h0;

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= `AXI_RESP_OKAY;
    end else if (wr_take) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx >= `REG_REF_FREQ_CFG_0 && rd_idx <= `REG_REF_FREQ_CFG_13) begin
      rd_byte = ref_freq_cfg_r[4'(rd_idx - `REG_REF_FREQ_CFG_0)];
    end else if (rd_idx >= `REG_PRIORITY_0 && rd_idx <= `REG_PRIORITY_6) begin
      rd_byte = {priority_r[4'({rd_idx - `REG_PRIORITY_0, 1'b1})],
                 priority_r[4'({rd_idx - `REG_PRIORITY_0, 1'b0})]};
    end else begin
      unique case (rd_idx)
        `REG_TEST_CONTROL: rd_byte = test_control_r;
        `REG_INPUT_NETWORK_CONFIG: rd_byte = input_network_config_r;
        `REG_DIFF_RX_SELECT: rd_byte = differential_receiver_select_r;
        `REG_DIVIDER_VALUE_A: rd_byte = divider_value_a_r;
        `REG_DIVIDER_VALUE_B: rd_byte = divider_value_b_r;
        `REG_AVAILABLE_LO: rd_byte = AVAILABLE_OUT[7:0];
        `REG_AVAILABLE_HI: rd_byte = {2'h0, AVAILABLE_OUT[13:8]};
        `REG_COMPOSITE_STATUS: rd_byte = {4'h0, ami_dev_r, loss_v[1:0]};
        `REG_CFG_ERROR_LO: rd_byte = err_v[7:0];
        `REG_CFG_ERROR_HI: rd_byte = {2'h0, err_v[13:8]};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h00000000;
      S_AXI_RRESP_OUT <= `AXI_RESP_OKAY;
    end else if (rd_take) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RDATA_OUT <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
      S_AXI_RRESP_OUT <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Boot: straps caught once after release
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      boot_r <= ST_HOLD;
    end else begin
      unique case (boot_r)
        ST_HOLD: boot_r <= ST_STRAP;
        ST_STRAP: boot_r <= ST_RUN;
        ST_RUN: boot_r <= ST_RUN;
        default: boot_r <= ST_HOLD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic wr_byte;
  assign wr_byte = wr_take && wr_hit && S_AXI_WSTRB_IN[0];

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      input_network_config_r <= `RST_INPUT_NETWORK_CONFIG;
    end else if (boot_r == ST_STRAP) begin
      input_network_config_r[`BIT_NETWORK_TYPE] <= NETWORK_TYPE_SELECT_IN;
    end else if (wr_byte && wr_idx == `REG_INPUT_NETWORK_CONFIG) begin
      input_network_config_r <= S_AXI_WDATA_IN[7:0];
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      test_control_r <= `RST_TEST_CONTROL;
      differential_receiver_select_r <= `RST_DIFF_RX_SELECT;
      divider_value_a_r <= `RST_DIVIDER_VALUE;
      divider_value_b_r <= `RST_DIVIDER_VALUE;
    end else if (wr_byte) begin
      unique case (wr_idx)
        `REG_TEST_CONTROL: test_control_r <= S_AXI_WDATA_IN[7:0];
        `REG_DIFF_RX_SELECT: differential_receiver_select_r <= S_AXI_WDATA_IN[7:0];
        `REG_DIVIDER_VALUE_A: divider_value_a_r <= S_AXI_WDATA_IN[7:0];
        `REG_DIVIDER_VALUE_B: divider_value_b_r <= S_AXI_WDATA_IN[7:0];
        default: test_control_r <= test_control_r;
      endcase
    end
  end

  // Shared N clamped into range; never divide by one
  assign divider_value_a_raw = {divider_value_b_r[`DIVIDER_VALUE_A_HI_MSB:0], divider_value_a_r};
  assign divider_value_a_eff = (divider_value_a_raw < `DIVIDER_VALUE_A_MIN) ? `DIVIDER_VALUE_A_MIN
    : (divider_value_a_raw > `DIVIDER_VALUE_A_MAX) ? `DIVIDER_VALUE_A_MAX : divider_value_a_raw;

  // ----------------------------------------------------------------
  // Per-input dividers and monitors
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REFS; gi++) begin : g_ref
      ref_cfg_t cfg;
      logic lvl_r;
      logic raw_ev;
      logic lock_ev;
      logic divided;
      logic [14:0] ratio;
      logic [14:0] div_cnt_r;
      logic [LW-1:0] idle_cnt_r;
      logic code_bad;

      assign cfg = ref_cfg_t'(ref_freq_cfg_r[gi]);
      assign divided = cfg.integer_divider_mode || cfg.auto_eight_khz_mode;

      always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
          ref_freq_cfg_r[gi] <= default_cfg(gi);
          priority_r[gi] <= 4'(gi + 2);
        end else if (boot_r == ST_STRAP && gi == PORT_ELEVEN) begin
          ref_freq_cfg_r[gi] <= MASTER_SLAVE_PIN_IN ? default_cfg(gi)
            : {4'h0, FC_6M48};
          priority_r[gi] <= MASTER_SLAVE_PIN_IN ? `PRIO_PORT_ELEVEN_MASTER
            : `PRIO_PORT_ELEVEN_SLAVE;
        end else if (wr_byte && wr_idx == 8'(`REG_REF_FREQ_CFG_0 + gi)) begin
          ref_freq_cfg_r[gi] <= S_AXI_WDATA_IN[7:0];
        end
      end

      always_comb begin
        if (cfg.integer_divider_mode) begin
          ratio = {1'b0, divider_value_a_eff} + 15'h0001;
        end else if (cfg.auto_eight_khz_mode) begin
          ratio = auto_ratio(cfg.freq_code, network_sonet);
        end else if (cfg.freq_code == FC_155M52) begin
          ratio = 15'h0002;
        end else begin
          ratio = 15'h0001;
        end
      end

      // Composite ports count decoder marks
      if (gi < 2) begin : g_ami_src
        assign raw_ev = ami_mark[gi];
        assign lock_ev = ami_mark[gi];
      end else begin : g_pin_src
        assign raw_ev = REF_IN[gi] ^ lvl_r;
        assign lock_ev = (divided && edge_falling) ? (lvl_r && !REF_IN[gi])
          : (!lvl_r && REF_IN[gi]);
      end

      // Bad setups are flagged, not silently run
      always_comb begin
        code_bad = (cfg.freq_code > FC_COMPOSITE);
        if (cfg.freq_code == FC_155M52 && gi != DIFF_A && gi != DIFF_B) begin
          code_bad = 1'b1;
        end
        if ((cfg.freq_code == FC_COMPOSITE) != (gi < 2)) begin
          code_bad = 1'b1;
        end
        if (cfg.auto_eight_khz_mode && (cfg.freq_code == FC_2K
            || cfg.freq_code == FC_4K || cfg.freq_code == FC_COMPOSITE)) begin
          code_bad = 1'b1;
        end
        if (cfg.integer_divider_mode && (cfg.auto_eight_khz_mode
            || cfg.freq_code != FC_8K)) begin
          code_bad = 1'b1;
        end
      end

      always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
          lvl_r <= 1'b0;
          div_cnt_r <= 15'h0000;
          PHASE_EVENT_OUT[gi] <= 1'b0;
        end else begin
          lvl_r <= REF_IN[gi];
          PHASE_EVENT_OUT[gi] <= 1'b0;
          if (lock_ev) begin
            if (div_cnt_r >= ratio - 15'h0001) begin
              div_cnt_r <= 15'h0000;
              PHASE_EVENT_OUT[gi] <= 1'b1;
            end else begin
              div_cnt_r <= div_cnt_r + 15'h0001;
            end
          end
        end
      end

      always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
          idle_cnt_r <= '0;
        end else if (raw_ev) begin
          idle_cnt_r <= '0;
        end else if (idle_cnt_r != LW'(LOSS_CYC)) begin
          idle_cnt_r <= idle_cnt_r + LW'(1);
        end
      end

      assign status[gi].loss = (idle_cnt_r == LW'(LOSS_CYC));
      assign status[gi].cfg_error = code_bad;
      assign status[gi].available = !status[gi].loss && !OUT_OF_BAND_IN[gi];
      assign status[gi].freq_check_en = !status[gi].loss && !IRREGULAR_IN[gi];
      assign loss_v[gi] = status[gi].loss;
      assign err_v[gi] = status[gi].cfg_error;
      assign AVAILABLE_OUT[gi] = status[gi].available;
      assign FREQ_CHECK_EN_OUT[gi] = status[gi].freq_check_en;
      assign PRIORITY_OUT[gi*4 +: 4] = priority_r[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Composite clock decoders
  // ----------------------------------------------------------------
  genvar ai;
  generate
    for (ai = 0; ai < 2; ai++) begin : g_ami
      logic last_pos_r;
      logic [3:0] marks_r;
      logic violation;

      assign ami_mark[ai] = AMI_POS_MARK_IN[ai] || AMI_NEG_MARK_IN[ai];
      // Repeated polarity breaks the coding
      assign violation = ami_mark[ai] && (AMI_POS_MARK_IN[ai] == last_pos_r);
      assign ami_dev_set[ai] = (violation && marks_r != `AMI_MARKS_PER_FRAME - 4'h1)
        || (ami_mark[ai] && !violation && marks_r >= `AMI_MARKS_PER_FRAME - 4'h1);

      always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
          last_pos_r <= 1'b0;
          marks_r <= 4'h0;
        end else if (ami_mark[ai]) begin
          last_pos_r <= AMI_POS_MARK_IN[ai];
          if (violation) begin
            marks_r <= 4'h0;
          end else if (marks_r < `AMI_MARKS_PER_FRAME) begin
            marks_r <= marks_r + 4'h1;
          end
        end
      end

      // Sticky, write-one-clear; set beats clear
      always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
          ami_dev_r[ai] <= 1'b0;
        end else begin
          ami_dev_r[ai] <= ami_dev_set[ai] || (ami_dev_r[ai] && !wr_clr[ai]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Frame dividers and sync alignment
  // ----------------------------------------------------------------
  logic sync_r;
  logic sync_rise;
  logic sync_is_2k;
  logic [FW-1:0] frame_cnt_r;
  logic [MW-1:0] mframe_cnt_r;

  assign sync_rise = SYNC_IN && !sync_r;
  assign sync_is_2k = (input_network_config_r[`SYNC_RATE_MSB:`SYNC_RATE_LSB] == SYNC_2K);

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sync_r <= 1'b0;
      frame_cnt_r <= '0;
      FRAME_8K_OUT <= 1'b0;
    end else begin
      sync_r <= SYNC_IN;
      if (sync_rise || frame_cnt_r == FW'(FRAME_8K_CYC - 1)) begin
        frame_cnt_r <= '0;
        FRAME_8K_OUT <= 1'b1;
      end else begin
        frame_cnt_r <= frame_cnt_r + FW'(1);
        FRAME_8K_OUT <= 1'b0;
      end
    end
  end

  // Only 2 kHz sync aligns the multiframe
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mframe_cnt_r <= '0;
      MFRAME_2K_OUT <= 1'b0;
    end else if ((sync_rise && sync_is_2k) || mframe_cnt_r == MW'(MFRAME_2K_CYC - 1)) begin
      mframe_cnt_r <= '0;
      MFRAME_2K_OUT <= 1'b1;
    end else begin
      mframe_cnt_r <= mframe_cnt_r + MW'(1);
      MFRAME_2K_OUT <= 1'b0;
    end
  end

endmodule : reference_input_conditioning

/* File: dv/refcond_checker.sv */
// Checker: bus, priorities, monitors, sync, lock events.
// Assumes straps change only in reset.
`timescale 1ns/1ps
module refcond_checker #(parameter int NUM_REFS = 14) (
  input wire logic CLK_IN, SYS_RST_IN, S_AXI_AWVALID_IN, S_AXI_WVALID_IN, S_AXI_BVALID_OUT,
  input wire logic S_AXI_ARVALID_IN, S_AXI_RVALID_OUT, SYNC_IN, MASTER_SLAVE_PIN_IN,
  input wire logic FRAME_8K_OUT,
  input wire logic [NUM_REFS-1:0] REF_IN, IRREGULAR_IN, OUT_OF_BAND_IN, PHASE_EVENT_OUT,
  input wire logic [NUM_REFS-1:0] FREQ_CHECK_EN_OUT, AVAILABLE_OUT,
  input wire logic [NUM_REFS*4-1:0] PRIORITY_OUT
);
  logic [1:0] up_r;
  // Straps land two edges after release
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  property p_wr; S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !S_AXI_BVALID_OUT |=> S_AXI_BVALID_OUT; endproperty
  a_wr: assert property (p_wr) else $error("write unanswered");
  property p_rd; S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT |=> S_AXI_RVALID_OUT; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_pri; PRIORITY_OUT[55:44] == 12'hFED && PRIORITY_OUT[39:0] == 40'hBA98765432; endproperty
  a_pri: assert property (p_pri) else $error("priority");
  property p_p11; up_r == 2'h3 |-> PRIORITY_OUT[43:40] == (MASTER_SLAVE_PIN_IN ? 4'hC : 4'h1); endproperty
  a_p11: assert property (p_p11) else $error("port eleven priority");
  property p_fck; (FREQ_CHECK_EN_OUT & IRREGULAR_IN) == '0; endproperty
  a_fck: assert property (p_fck) else $error("freq gating");
  property p_av; (AVAILABLE_OUT & OUT_OF_BAND_IN) == '0; endproperty
  a_av: assert property (p_av) else $error("availability");
  property p_syn; up_r == 2'h3 && $rose(SYNC_IN) |=> FRAME_8K_OUT; endproperty
  a_syn: assert property (p_syn) else $error("frame sync");
  property p_dir; up_r == 2'h3 && $rose(REF_IN[6]) |=> PHASE_EVENT_OUT[6]; endproperty
  a_dir: assert property (p_dir) else $error("direct event");
  c_wr: cover property (S_AXI_AWVALID_IN && S_AXI_WVALID_IN);
  c_syn: cover property ($rose(SYNC_IN));
  c_lost: cover property (!AVAILABLE_OUT[3]);
endmodule : refcond_checker
bind reference_input_conditioning refcond_checker #(.NUM_REFS(NUM_REFS)) u_chk (.*);

/* File: dv/ref_source_model.sv */
// Far side: reference clocks at one rate, composite marks.
// Assumes one clock; a stopped source holds its level.
`timescale 1ns/1ps
module ref_source_model (
  input wire logic clk_in,
  input wire logic [13:0] run_in,
  input wire logic bad_frame_in,
  output logic [13:0] ref_out = 14'h0,
  output logic [1:0] pos_out = 2'h0,
  output logic [1:0] neg_out = 2'h0
);
  logic [1:0] ph_r = 2'h0;
  logic [2:0] mark_r = 3'h0;
  logic pol_r = 1'b0;
  logic pol_nxt;
  assign pol_nxt = (mark_r == 3'h7 && !bad_frame_in) ? pol_r : !pol_r;
  always @(posedge clk_in) begin
    ph_r <= ph_r + 2'h1;
    if (ph_r[0]) ref_out <= ref_out ^ run_in;
    pos_out <= (ph_r == 2'h3) ? {2{pol_nxt}} : 2'h0;
    neg_out <= (ph_r == 2'h3) ? {2{!pol_nxt}} : 2'h0;
    if (ph_r == 2'h3) mark_r <= mark_r + 3'h1;
    if (ph_r == 2'h3) pol_r <= pol_nxt;
  end
endmodule : ref_source_model

/* File: dv/reference_input_conditioning_tb_top.sv */
// Bench: registers, dividers, loss, sync, composite frames.
// Assumes package, design and model compiled first.
`timescale 1ns/1ps
module reference_input_conditioning_tb_top;
  localparam int PER = 4;
  logic clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, snc = 0, bad = 0;
  logic awr, wrd, bv, arr, rv, son, m2, f8;
  logic [55:0] pri;
  logic [11:0] adr = 0;
  logic [31:0] wd = 0, rd, q;
  logic [13:0] run = 14'h3FFF, irr = 0, oob = 0, refs, pev, av, fce;
  logic [1:0] br, rr, r, pos, neg, pecl;
  int seed = 32'h0E17124F, miscompares = 0, total_checks = 0;
  reference_input_conditioning #(.FRAME_8K_CYC(20), .MFRAME_2K_CYC(80), .LOSS_CYC(30)) dut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .S_AXI_AWADDR_IN(adr), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(1'b1),
    .S_AXI_ARADDR_IN(adr), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd),
    .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(1'b1),
    .NETWORK_TYPE_SELECT_IN(1'b1), .MASTER_SLAVE_PIN_IN(1'b1), .REF_IN(refs),
    .AMI_POS_MARK_IN(pos), .AMI_NEG_MARK_IN(neg), .SYNC_IN(snc), .IRREGULAR_IN(irr),
    .OUT_OF_BAND_IN(oob), .PHASE_EVENT_OUT(pev), .FREQ_CHECK_EN_OUT(fce), .AVAILABLE_OUT(av),
    .PRIORITY_OUT(pri), .DIFF_PECL_SEL_OUT(pecl), .NETWORK_SONET_OUT(son), .FRAME_8K_OUT(f8),
    .MFRAME_2K_OUT(m2));
  ref_source_model src (.clk_in(clk), .run_in(run), .bad_frame_in(bad), .ref_out(refs),
    .pos_out(pos), .neg_out(neg));
  initial forever #5 clk = ~clk;
  // Low ports stay in band
  always @(posedge clk) {irr, oob} <= {14'($random(seed)), 2'($random(seed)), 12'h0};
  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      miscompares++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  task automatic bus(input bit w, input logic [7:0] ix, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    adr <= {2'h0, ix, 2'h0};
    wd <= {24'h0, d};
    if (w) {awv, wv} <= 2'h3;
    else arv <= 1'b1;
    do @(negedge clk); while (!(w ? awr && wrd : arr) && ++n < 40);
    @(posedge clk);
    {awv, wv, arv} <= 3'h0;
    do @(negedge clk); while (!(w ? bv : rv) && ++n < 40);
    q = rd;
    r = w ? br : rr;
    @(posedge clk);
    if (n >= 40) chk(0, "bus hang");
    if (n >= 40) end_of_test();
  endtask : bus
  task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
    bus(1'b0, ix, 8'h0);
    chk(q === {24'h0, e} && r === 2'h0, "read value");
  endtask : rdc
  task automatic gap(input int p, input int e);
    int n = 0, a = 0;
    while (a < 2 && n < 2000) begin
      @(negedge clk);
      n++;
      if (pev[p] === 1'b1 && ++a == 1) n = 0;
    end
    chk(n == e, "event spacing");
  endtask : gap
  function automatic logic [7:0] cfg_rst(input int i);
    return i < 2 ? 8'h0B : i < 4 ? 8'h00 : i < 10 ? 8'h03 : 8'h01;
  endfunction : cfg_rst
  initial begin
    logic [7:0] nv;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 14; i++) rdc(8'h20 + 8'(i), cfg_rst(i));
    rdc(8'h36, 8'h02);
    rdc(8'h34, 8'h04);
    bus(1'b0, 8'h10, 8'h0);
    chk(r === 2'h2 && q === 32'h0, "unmapped");
    bus(1'b1, 8'h36, 8'h01);
    chk(pecl === 2'h1 && pri[43:40] === 4'hC, "receiver select");
    gap(6, PER);
    bus(1'b1, 8'h24, 8'h08);
    gap(4, 2 * PER);
    for (int k = 0; k < 2; k++) begin
      nv = k == 0 ? 8'h01 : 8'h02 + 8'($unsigned($random(seed)) % 6);
      bus(1'b1, 8'h47, 8'h00);
      bus(1'b1, 8'h46, nv);
      bus(1'b1, 8'h22 + 8'(k), {2'h2, 2'(k + 2), 4'h0});
      gap(2 + k, (nv + 1) * PER);
    end
    bus(1'b1, 8'h2B, 8'h41);
    gap(11, 1544 / 8 * PER);
    bus(1'b1, 8'h34, 8'h00);
    chk(son === 1'b0, "network type");
    gap(11, 2048 / 8 * PER);
    run[3] <= 1'b0;
    repeat (60) @(posedge clk);
    chk(av[3] === 1'b0 && fce[3] === 1'b0, "loss");
    snc <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(m2 === 1'b1 && f8 === 1'b1, "multiframe");
    bus(1'b1, 8'h52, 8'h0C);
    snc <= 1'b0;
    repeat (40) @(posedge clk);
    rdc(8'h52, 8'h00);
    bad <= 1'b1;
    repeat (40) @(posedge clk);
    rdc(8'h52, 8'h0C);
    end_of_test();
  end
endmodule : reference_input_conditioning_tb_top
